/* File: arr_regs.sv */
// Converter reference control and conversion result registers.
// Assumes an AXI4-Lite master on sys_clk_i and a converter core that
// pulses sample_valid_i for one cycle per completed conversion.
//
// Function
// - High and low bits select reference source
// - Codes 01/10 give 1.0V/2.0V, reset 10
// - Reference independent of comparator level setting
// - Result is 11-bit two's complement
// - High byte holds upper eight result bits
// - High byte read latches low bits
// - Result invalid during single-shot conversion
// - Continuous mode keeps most recent result
// - Low register bits 7:5 hold LSBs
// - Bit 0 flags digital filter overflow
// - Low register bits 4:1 undefined
// - Result registers are read-only
// - Result bits need no reset value
`timescale 1ns/1ps
module arr_regs (
    input  wire logic                 sys_clk_i,       // 25 MHz clock
    input  wire logic                 rstn_i,          // Async reset, low
    // AXI4-Lite write address
    input  wire logic [13:0]          s_axi_awaddr,    // Write address
    input  wire logic                 s_axi_awvalid,   // Address valid
    output logic                      s_axi_awready,   // Address ready
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata,     // Write data
    input  wire logic [3:0]           s_axi_wstrb,     // Byte strobes
    input  wire logic                 s_axi_wvalid,    // Data valid
    output logic                      s_axi_wready,    // Data ready
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,     // Write response
    output logic                      s_axi_bvalid,    // Response valid
    input  wire logic                 s_axi_bready,    // Response ready
    // AXI4-Lite read address
    input  wire logic [13:0]          s_axi_araddr,    // Read address
    input  wire logic                 s_axi_arvalid,   // Address valid
    output logic                      s_axi_arready,   // Address ready
    // AXI4-Lite read data
    output logic [31:0]               s_axi_rdata,     // Read data
    output logic [1:0]                s_axi_rresp,     // Read response
    output logic                      s_axi_rvalid,    // Data valid
    input  wire logic                 s_axi_rready,    // Data ready
    // Converter core side
    input  wire arr_pkg::arr_sample_t sample_i,        // Finished sample
    input  wire logic                 sample_valid_i,  // Sample strobe
    input  wire logic                 conv_busy_i,     // Single-shot busy
    input  wire logic                 ref_sel_low_i,   // Low select bit
    output arr_pkg::arr_ref_t         ref_sel_o,       // Reference source
    output logic                      int_ref_en_o,    // Internal ref on
    output logic                      irq_o            // Interrupt level
);
    import arr_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Byte address of a register index
    // Offsets are word indices, so the byte address is index times 4
    function automatic logic [ARR_ADDR_W-1:0] reg_addr(
        input logic [11:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic                 ref_high_q;
    logic [ARR_RES_W-1:0] result_q;
    logic                 ovf_q;
    logic [ARR_RES_HI_LSB-1:0] low_bits_q;
    logic                 low_ovf_q;
    logic [ARR_IRQ_W-1:0] irq_stat_q;
    logic [ARR_IRQ_W-1:0] irq_mask_q;
    logic [ARR_IRQ_W-1:0] irq_set;
    logic [ARR_IRQ_W-1:0] irq_clr;
    logic                 aw_held_q;
    logic                 w_held_q;
    logic [13:0]          awaddr_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic                 wr_fire;
    logic                 rd_fire;
    logic                 wr_hit;
    logic                 wr_ref_en;
    logic                 wr_sta_en;
    logic                 wr_msk_en;
    arr_rd_t              rd_dec;
    logic                 unread_q;

    // ---------------------------------------------------------------
    // Write channel: address and data taken in either order
    // ---------------------------------------------------------------
    // Each ready drops once its beat is held, so the master waits.
    // Keeping one write in flight lets the decode below be a plain
    // compare on the held address.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 14'h0000;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Both halves held and no response pending
    // The write takes effect at the end of this cycle, on the edge that raises bvalid
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    // Result registers are not writable; a write there is accepted
    // and answered OKAY, so a stray write there is harmless
    always_comb begin
        wr_hit = 1'b0;
        if (awaddr_q == reg_addr(ARR_IDX_REF_CTL)) begin
            wr_hit = 1'b1;
        end else if (awaddr_q == reg_addr(ARR_IDX_RES_HI)) begin
            wr_hit = 1'b1;
        end else if (awaddr_q == reg_addr(ARR_IDX_RES_LO)) begin
            wr_hit = 1'b1;
        end else if (awaddr_q == reg_addr(ARR_IDX_IRQ_STAT)) begin
            wr_hit = 1'b1;
        end else if (awaddr_q == reg_addr(ARR_IDX_IRQ_MASK)) begin
            wr_hit = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Write decode
    // ---------------------------------------------------------------
    // One enable per stored register. Byte lane 0 must be on: a write
    // without it is still answered but stores nothing.
    always_comb begin
        wr_ref_en = 1'b0;
        wr_sta_en = 1'b0;
        wr_msk_en = 1'b0;
        if (wr_fire && wstrb_q[0]) begin
            if (awaddr_q == reg_addr(ARR_IDX_REF_CTL)) begin
                wr_ref_en = 1'b1;
            end else if (awaddr_q == reg_addr(ARR_IDX_IRQ_STAT)) begin
                wr_sta_en = 1'b1;
            end else if (awaddr_q == reg_addr(ARR_IDX_IRQ_MASK)) begin
                wr_msk_en = 1'b1;
            end
        end
    end

    // Write response
    // bvalid stands until bready; bresp only means something while
    // it does
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ARR_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? ARR_RESP_OKAY : ARR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Reference control register
    // ---------------------------------------------------------------
    // Only bit 7 is stored; reserved bits are expected as zero and
    // read back as zero. Comparator level lives elsewhere.
    // Nothing here touches the comparator, so neither setting moves
    // the other.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_high_q <= ARR_REFH_RST;
        end else if (wr_ref_en) begin
            ref_high_q <= wdata_q[ARR_REFH_BIT];
        end
    end

    // Reference decode into the analog select lines
    // The code is registered, so the select lines move one cycle after
    // a write or a change of the low bit, and only on a clock edge.
    arr_ref_decode u_ref_decode (
        .sys_clk_i  (sys_clk_i),
        .rstn_i     (rstn_i),
        .sel_high_i (ref_high_q),
        .sel_low_i  (ref_sel_low_i),
        .ref_sel_o  (ref_sel_o),
        .int_ref_o  (int_ref_en_o)
    );

    // ---------------------------------------------------------------
    // Conversion result capture
    // ---------------------------------------------------------------
    // No reset: contents are undefined until the first conversion.
    // Each finished sample overwrites, so continuous mode always
    // shows the newest one; mid-conversion values are not promised.
    // The busy input is not consulted: software waits for the end.
    always_ff @(posedge sys_clk_i) begin
        if (sample_valid_i) begin
            result_q <= sample_i.value;
            ovf_q    <= sample_i.filter_ovf;
        end
    end

    // Low bits latched on a high-byte read and held until the next.
    // A slow reader still gets a matched pair; the price is that the
    // low register shows the old sample until the high byte is read.
    always_ff @(posedge sys_clk_i) begin
        if (rd_fire && rd_dec.res_hi) begin
            low_bits_q <= result_q[ARR_RES_HI_LSB-1:0];
            low_ovf_q  <= ovf_q;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt status and mask
    // ---------------------------------------------------------------
    // Events: sample done, filter overflow, sample overwritten unread
    // Unread marks a sample whose high byte has not been read yet; a
    // new sample while it is set is an overrun.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            unread_q <= 1'b0;
        end else if (sample_valid_i) begin
            unread_q <= 1'b1;
        end else if (rd_fire && rd_dec.res_hi) begin
            unread_q <= 1'b0;
        end
    end

    // One set pulse per event, all in the cycle of the sample strobe
    always_comb begin
        irq_set                = '0;
        irq_set[ARR_IRQ_DONE]  = sample_valid_i;
        irq_set[ARR_IRQ_OVF]   = sample_valid_i && sample_i.filter_ovf;
        irq_set[ARR_IRQ_OVRUN] = sample_valid_i && unread_q;
    end

    // Write one to clear; zeros leave their bits alone
    assign irq_clr = wr_sta_en ? wdata_q[ARR_IRQ_W-1:0] : '0;

    // A set in the clearing cycle wins over the clear
    // so no event is lost to a clear of an older one
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat_q <= ARR_IRQ_RST;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    // Mask, same layout as the status bits
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_mask_q <= ARR_IRQ_RST;
        end else if (wr_msk_en) begin
            irq_mask_q <= wdata_q[ARR_IRQ_W-1:0];
        end
    end

    // Registered level, one cycle behind the status bits
    // The lag buys a glitch-free output straight from a flip-flop
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ---------------------------------------------------------------
    // Read channel
    // ---------------------------------------------------------------
    // Read address taken on this edge
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // Reserved low bits 4:1 read as zero
    // The address is decoded at the handshake itself, so the read data
    // and the low-bit latch see the same cycle.
    always_comb begin
        rd_dec = '0;
        if (s_axi_araddr == reg_addr(ARR_IDX_REF_CTL)) begin
            rd_dec.hit  = 1'b1;
            rd_dec.data = {24'h000000, ref_high_q, 7'h00};
        end else if (s_axi_araddr == reg_addr(ARR_IDX_RES_HI)) begin
            rd_dec.hit    = 1'b1;
            rd_dec.res_hi = 1'b1;
            rd_dec.data   = {24'h000000,
                             result_q[ARR_RES_W-1:ARR_RES_HI_LSB]};
        end else if (s_axi_araddr == reg_addr(ARR_IDX_RES_LO)) begin
            rd_dec.hit  = 1'b1;
            rd_dec.data = {24'h000000, low_bits_q, 4'h0,
                           low_ovf_q};
        end else if (s_axi_araddr == reg_addr(ARR_IDX_IRQ_STAT)) begin
            rd_dec.hit  = 1'b1;
            rd_dec.data = {29'h00000000, irq_stat_q};
        end else if (s_axi_araddr == reg_addr(ARR_IDX_IRQ_MASK)) begin
            rd_dec.hit  = 1'b1;
            rd_dec.data = {29'h00000000, irq_mask_q};
        end
    end

    // One read at a time; address ready drops until data is taken
    // rvalid and its payload stand until rready is seen high
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= ARR_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_dec.data;
            s_axi_rresp   <= rd_dec.hit ? ARR_RESP_OKAY : ARR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

/* File: arr_pkg.sv */
// Package for the converter reference and result register slice.
// Assumes AXI4-Lite access with 32-bit data and one register per word.
package arr_pkg;

    // ---------------------------------------------------------------
    // Register map (byte addresses, printed offsets are indices)
    // ---------------------------------------------------------------
    localparam logic [11:0] ARR_IDX_REF_CTL  = 12'hF71;
    localparam logic [11:0] ARR_IDX_RES_HI   = 12'hF72;
    localparam logic [11:0] ARR_IDX_RES_LO   = 12'hF73;
    localparam logic [11:0] ARR_IDX_IRQ_STAT = 12'hF74;
    localparam logic [11:0] ARR_IDX_IRQ_MASK = 12'hF75;
    localparam int          ARR_ADDR_W       = 14;

    // ---------------------------------------------------------------
    // Field layout and reset values
    // ---------------------------------------------------------------
    localparam int         ARR_RES_W       = 11;
    localparam int         ARR_RES_HI_LSB  = 3;  // Low field width
    localparam int         ARR_REFH_BIT    = 7;
    localparam logic       ARR_REFH_RST    = 1'b1;
    localparam logic [2:0] ARR_IRQ_RST     = 3'h0;
    localparam int         ARR_IRQ_W       = 3;
    localparam int         ARR_IRQ_DONE    = 0;
    localparam int         ARR_IRQ_OVF     = 1;
    localparam int         ARR_IRQ_OVRUN   = 2;
    localparam logic [1:0] ARR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ARR_RESP_SLVERR = 2'h2;

    // Reference source encodings {high bit, low bit}
    typedef enum logic [1:0] {
        ARR_REF_EXT  = 2'b00,
        ARR_REF_1V0  = 2'b01,
        ARR_REF_2V0  = 2'b10,
        ARR_REF_RSVD = 2'b11
    } arr_ref_t;

    // One completed conversion from the converter core
    typedef struct packed {
        logic [10:0] value;
        logic        filter_ovf;
    } arr_sample_t;

    // Read-side decode result
    typedef struct packed {
        logic        hit;
        logic        res_hi;
        logic [31:0] data;
    } arr_rd_t;

endpackage

/* File: arr_ref_decode.sv */
// Reference source decoder for the converter.
// Assumes both select bits come from registers on the same clock.
`timescale 1ns/1ps
module arr_ref_decode (
    input  wire logic            sys_clk_i,  // System clock
    input  wire logic            rstn_i,     // Async reset, active low
    input  wire logic            sel_high_i, // High select bit
    input  wire logic            sel_low_i,  // Low select bit
    output arr_pkg::arr_ref_t    ref_sel_o,  // Decoded source, registered
    output logic                 int_ref_o   // Internal reference enabled
);
    import arr_pkg::*;

    // ---------------------------------------------------------------
    // Registered decode
    // ---------------------------------------------------------------
    // Code 00 turns the internal reference off and uses the pin
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_sel_o <= ARR_REF_2V0;
            int_ref_o <= 1'b1;
        end else begin
            ref_sel_o <= arr_ref_t'({sel_high_i, sel_low_i});
            int_ref_o <= (sel_high_i | sel_low_i);
        end
    end

endmodule

/* File: arr_regs_props.sv */
// Checker for the converter reference and result register slice.
// Assumes it is bound to arr_regs and sees only that module's ports.
`timescale 1ns/1ps
module arr_regs_props (
    input wire logic              sys_clk_i,     // Clock
    input wire logic              rstn_i,        // Reset, active low
    input wire logic              s_axi_awready, // AW ready
    input wire logic              s_axi_wready,  // W ready
    input wire logic              s_axi_bvalid,  // B valid
    input wire logic              s_axi_bready,  // B ready
    input wire logic              s_axi_arvalid, // AR valid
    input wire logic              s_axi_arready, // AR ready
    input wire logic              s_axi_rvalid,  // R valid
    input wire logic              s_axi_rready,  // R ready
    input wire logic              ref_sel_low_i, // Low select bit
    input wire arr_pkg::arr_ref_t ref_sel_o,     // Reference code
    input wire logic              int_ref_en_o   // Internal ref on
);
    import arr_pkg::*;
    // ---------------------------------------------------------------
    // Sequences and properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_done;
        s_axi_rvalid && s_axi_rready;
    endsequence
    // Low bit is registered once; reset edge excluded on purpose
    a_ref_low_track: assert property (
        $past(rstn_i) |-> ref_sel_o[0] == $past(ref_sel_low_i))
        else $error("reference low bit not followed");
    a_int_ref_code: assert property (
        int_ref_en_o == (ref_sel_o != ARR_REF_EXT))
        else $error("internal reference enable wrong");
    a_ref_reset_val: assert property (
        $rose(rstn_i) |-> ref_sel_o == ARR_REF_2V0)
        else $error("reference code not 2.0V after reset");
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_rd_release: assert property (s_rd_done |=> !s_axi_rvalid)
        else $error("read valid held after handshake");
    a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_wr_release: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    a_wr_refuse: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule

bind arr_regs arr_regs_props arr_regs_props_inst (
    .sys_clk_i     (sys_clk_i),
    .rstn_i        (rstn_i),
    .s_axi_awready (s_axi_awready),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .ref_sel_low_i (ref_sel_low_i),
    .ref_sel_o     (ref_sel_o),
    .int_ref_en_o  (int_ref_en_o)
);

/* File: arr_regs_tb_top.sv */
// Self-checking bench for the reference and result register slice.
// Assumes the byte address of each register is four times its index.
`timescale 1ns/1ps
module arr_regs_tb_top;
    import arr_pkg::*;
    localparam logic [13:0] A_REF = {ARR_IDX_REF_CTL, 2'b00};
    localparam logic [13:0] A_HI  = {ARR_IDX_RES_HI, 2'b00};
    localparam logic [13:0] A_LO  = {ARR_IDX_RES_LO, 2'b00};
    localparam logic [13:0] A_STA = {ARR_IDX_IRQ_STAT, 2'b00};
    localparam logic [13:0] A_MSK = {ARR_IDX_IRQ_MASK, 2'b00};
    localparam logic [1:0]  OK    = ARR_RESP_OKAY;
    logic        sys_clk_i = 1'b0, rstn_i = 1'b0;
    logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, int_ref_en_o, irq_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    arr_sample_t sample_i = '0;
    logic        sample_valid_i = 0, conv_busy_i = 0, ref_sel_low_i = 0;
    arr_ref_t    ref_sel_o;
    int          fail_count = 0, cmp_count = 0;

    arr_regs arr_regs_inst (
        .sys_clk_i      (sys_clk_i),
        .rstn_i         (rstn_i),
        .s_axi_awaddr   (s_axi_awaddr),
        .s_axi_awvalid  (s_axi_awvalid),
        .s_axi_awready  (s_axi_awready),
        .s_axi_wdata    (s_axi_wdata),
        .s_axi_wstrb    (s_axi_wstrb),
        .s_axi_wvalid   (s_axi_wvalid),
        .s_axi_wready   (s_axi_wready),
        .s_axi_bresp    (s_axi_bresp),
        .s_axi_bvalid   (s_axi_bvalid),
        .s_axi_bready   (s_axi_bready),
        .s_axi_araddr   (s_axi_araddr),
        .s_axi_arvalid  (s_axi_arvalid),
        .s_axi_arready  (s_axi_arready),
        .s_axi_rdata    (s_axi_rdata),
        .s_axi_rresp    (s_axi_rresp),
        .s_axi_rvalid   (s_axi_rvalid),
        .s_axi_rready   (s_axi_rready),
        .sample_i       (sample_i),
        .sample_valid_i (sample_valid_i),
        .conv_busy_i    (conv_busy_i),
        .ref_sel_low_i  (ref_sel_low_i),
        .ref_sel_o      (ref_sel_o),
        .int_ref_en_o   (int_ref_en_o),
        .irq_o          (irq_o)
    );

    // Clock at 25 MHz
    always #20 sys_clk_i = ~sys_clk_i;

    // ---------------------------------------------------------------
    // Checking and bus tasks
    // ---------------------------------------------------------------
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Hung handshake counts as a mismatch and closes the run
    task automatic give_up(input int n);
        if (n >= 50) begin
            fail_count++;
            conclude();
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        give_up(n);
    endtask
    // Data is compared only when the answer is expected to be OKAY
    task automatic rd(input logic [13:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        if (er == OK) chk(s_axi_rdata, e);
        give_up(n);
    endtask
    // One finished conversion, a single-cycle strobe
    task automatic smp(input logic [10:0] v, input logic o);
        @(posedge sys_clk_i);
        sample_i       <= {v, o};
        sample_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        sample_valid_i <= 1'b0;
    endtask
    task automatic settle;
        @(posedge sys_clk_i);
        #1;
    endtask

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        rd(A_REF, 32'h80, OK);
        chk({30'h0, ref_sel_o}, 32'h2);
        chk({31'h0, int_ref_en_o}, 32'h1);
        rd(A_MSK, 32'h0, OK);
        $display("test reset_values done");
        for (int c = 0; c < 4; c++) begin
            @(posedge sys_clk_i);
            ref_sel_low_i <= c[0];
            wr(A_REF, {24'h0, c[1], 7'h00}, OK);
            settle();
            chk({30'h0, ref_sel_o}, c);
            chk({31'h0, int_ref_en_o}, {31'h0, c != 0});
            rd(A_REF, {24'h0, c[1], 7'h00}, OK);
        end
        $display("test reference_codes done");
        smp(11'h5A3, 1'b1);
        rd(A_HI, 32'hB4, OK);
        smp(11'h2C6, 1'b0);
        rd(A_LO, 32'h61, OK);
        rd(A_HI, 32'h58, OK);
        rd(A_LO, 32'hC0, OK);
        wr(A_HI, 32'hFF, OK);
        wr(A_LO, 32'hFF, OK);
        rd(A_HI, 32'h58, OK);
        rd(A_LO, 32'hC0, OK);
        $display("test result_registers done");
        // Two samples with no high read between them give an overrun
        smp(11'h7FF, 1'b0);
        smp(11'h400, 1'b1);
        rd(A_STA, 32'h7, OK);
        chk({31'h0, irq_o}, 32'h0);
        wr(A_MSK, 32'h2, OK);
        settle();
        chk({31'h0, irq_o}, 32'h1);
        wr(A_STA, 32'h2, OK);
        settle();
        chk({31'h0, irq_o}, 32'h0);
        rd(A_STA, 32'h5, OK);
        // Byte lane 0 off: answered, but the mask keeps its value
        @(posedge sys_clk_i);
        s_axi_wstrb <= 4'h0;
        wr(A_MSK, 32'h7, OK);
        s_axi_wstrb <= 4'hF;
        rd(A_MSK, 32'h2, OK);
        $display("test interrupts done");
        wr(14'h0000, 32'h1, ARR_RESP_SLVERR);
        rd(14'h0000, 32'h0, ARR_RESP_SLVERR);
        $display("test unmapped done");
        conclude();
    end
endmodule
